// ### hw/emb_pkg.sv
package emb_pkg;

   // Storage and word geometry
   localparam int unsigned EMB_BITS = 2048;          // Fixed capacity in every shape
   localparam int unsigned EMB_AW   = 11;            // Widest word address
   localparam int unsigned EMB_DW   = 8;             // Widest word
   localparam int unsigned EMB_CW   = 12;            // FIFO level width

   // Register byte offsets
   localparam logic [7:0] EMB_OFS_CTRL = 8'h00;      // Mode, shape, register enables
   localparam logic [7:0] EMB_OFS_LDAD = 8'h04;      // Preload word address
   localparam logic [7:0] EMB_OFS_LDDT = 8'h08;      // Preload word data
   localparam logic [7:0] EMB_OFS_STAT = 8'h0c;      // FIFO level and flags
   localparam logic [7:0] EMB_OFS_CASC = 8'h10;      // Depth cascade enable and id

   // Status field positions
   localparam int unsigned EMB_STAT_EMPTY = 12;      // FIFO empty
   localparam int unsigned EMB_STAT_FULL  = 13;      // FIFO full
   localparam int unsigned EMB_STAT_DONE  = 14;      // Configuration locked

   // Cascade field positions
   localparam int unsigned EMB_CASC_EN = 3;          // Cascade enable bit

   // Values after reset
   localparam logic [7:0] EMB_CTRL_RST = 8'h00;      // RAM, 256x8, no registers
   localparam logic [3:0] EMB_CASC_RST = 4'h0;       // Cascade off, id 0

   // Operating modes
   typedef enum logic [1:0]
   {
      EMB_MODE_RAM  = 2'h0,
      EMB_MODE_ROM  = 2'h1,
      EMB_MODE_DPRAM = 2'h2,
      EMB_MODE_FIFO = 2'h3
   } emb_mode_e;

   // Word shapes
   typedef enum logic [1:0]
   {
      EMB_SHP_256X8  = 2'h0,
      EMB_SHP_512X4  = 2'h1,
      EMB_SHP_1024X2 = 2'h2,
      EMB_SHP_2048X1 = 2'h3
   } emb_shape_e;

   // Configuration word, bit 7 down to bit 0
   typedef struct packed
   {
      logic       done;      // Locks preload, opens user ports
      logic       reg_dout;  // Output register enable
      logic       reg_addr;  // Address and write-enable register
      logic       reg_din;   // Data input register
      emb_shape_e shape;     // Word shape
      emb_mode_e  mode;      // Operating mode
   } emb_cfg_s;

   // User-side inputs from the logic array
   typedef struct packed
   {
      logic        in_ce;    // Input-side clock enable
      logic        out_ce;   // Output-side clock enable
      logic        we;       // Write enable or FIFO push
      logic        pop;      // FIFO pop
      logic [10:0] addr;     // Write / read address
      logic [10:0] rd_addr;  // Second-port read address
      logic [7:0]  din;      // Write data
   } emb_usr_in_s;

   // User-side outputs to the logic array
   typedef struct packed
   {
      logic [7:0] dout;      // Read data, zero when not selected; with the output register, zero follows one enabled cycle later
      logic       sel;       // This block answers the read address
      logic       full;      // FIFO full
      logic       empty;     // FIFO empty
   } emb_usr_out_s;

   // Single write port of the storage array
   typedef struct packed
   {
      logic        en;
      logic [10:0] addr;
      logic [7:0]  data;
   } emb_wr_s;

   // Storage array state
   typedef struct packed
   {
      logic [EMB_BITS-1:0] bits;
   } emb_core_s;

   // Mask of valid word address bits for a shape
   function automatic logic [10:0] emb_amask(emb_shape_e s);
      case (s)
         EMB_SHP_256X8:  emb_amask = 11'h0ff;
         EMB_SHP_512X4:  emb_amask = 11'h1ff;
         EMB_SHP_1024X2: emb_amask = 11'h3ff;
         default:        emb_amask = 11'h7ff;
      endcase
   endfunction

   // Address bit count for a shape
   function automatic logic [3:0] emb_dbits(emb_shape_e s);
      case (s)
         EMB_SHP_256X8:  emb_dbits = 4'h8;
         EMB_SHP_512X4:  emb_dbits = 4'h9;
         EMB_SHP_1024X2: emb_dbits = 4'ha;
         default:        emb_dbits = 4'hb;
      endcase
   endfunction

   // Valid data lanes for a shape
   function automatic logic [7:0] emb_wmask(emb_shape_e s);
      case (s)
         EMB_SHP_256X8:  emb_wmask = 8'hff;
         EMB_SHP_512X4:  emb_wmask = 8'h0f;
         EMB_SHP_1024X2: emb_wmask = 8'h03;
         default:        emb_wmask = 8'h01;
      endcase
   endfunction

endpackage

// ### hw/emb_mem_core.sv
`timescale 1ns/1ps

// 2048-bit array, one write port and one read port
module emb_mem_core
(
   input  wire logic                sys_clk,
   input  wire emb_pkg::emb_shape_e shape,
   input  wire emb_pkg::emb_wr_s    wr,
   input  wire logic [10:0]         rd_addr,
   output logic [7:0]               rd_data
);

   emb_pkg::emb_core_s st_r;    // Stored bits
   emb_pkg::emb_core_s st_nxt;  // Next stored bits
   logic [10:0]        wbase;   // First bit of written word
   logic [10:0]        rbase;   // First bit of read word
   logic [7:0]         lanes;   // Valid lanes for shape

   // Word address to bit index: word times width
   always_comb
   begin
      lanes = emb_pkg::emb_wmask(shape);
      wbase = wr.addr << (3 - shape);
      rbase = rd_addr << (3 - shape);
      st_nxt = st_r;
      for (int i = 0; i < 8; i++)
      begin
         // Only the lanes of the shape are touched
         if (wr.en && lanes[i])
         begin
            st_nxt.bits[wbase + 11'(i)] = wr.data[i];
         end
         // Read sees stored bits, so a same-cycle write shows old data
         rd_data[i] = lanes[i] & st_r.bits[rbase + 11'(i)];
      end
   end

   // Storage flops carry no reset; contents come from preload or writes
   always_ff @(posedge sys_clk)
   begin
      st_r <= st_nxt;
   end

endmodule

// ### hw/emb_memory_block.sv
`timescale 1ns/1ps

// Summary of operation
// - Block always stores exactly 2048 bits
// - Modes: RAM, ROM, dual-port RAM, FIFO
// - Shapes 256x8, 512x4, 1024x2, 2048x1
// - Write strobe made inside, timed to clock
// - Input and output sides on one clock, each with its own clock enable
// - Data, address, output registers each optional
// - Blocks sharing address combine for width
// - Upper address bits select cascaded block
// - ROM contents preloaded before use
module emb_memory_block
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic [7:0]            bus_addr,
   input  wire logic [31:0]           bus_wdata,
   input  wire logic                  bus_wr,
   input  wire logic                  bus_rd,
   output logic [31:0]                bus_rdata,
   input  wire emb_pkg::emb_usr_in_s  usr_i,
   output emb_pkg::emb_usr_out_s      usr_o
);

   ////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////

   // Whole module state in one word
   typedef struct packed
   {
      emb_pkg::emb_cfg_s cfg;        // Configuration
      logic [3:0]        casc;       // Cascade enable and id
      logic [10:0]       load_addr;  // Preload pointer
      logic [7:0]        din_q;      // Input data register
      logic [10:0]       addr_q;     // Address register
      logic [10:0]       rda_q;      // Second-port address register
      logic              we_q;       // Write-enable register
      logic [7:0]        dout_q;     // Output register
      logic [10:0]       wptr;       // FIFO write pointer
      logic [10:0]       rptr;       // FIFO read pointer
      logic [11:0]       count;      // FIFO level
      logic [31:0]       rdata;      // Bus read answer
   } emb_top_s;

   emb_top_s           st_r;       // Registered state
   emb_top_s           st_nxt;     // Next state

   ////////////////////////////////////////////////////////////////
   // Datapath wires
   ////////////////////////////////////////////////////////////////

   logic [7:0]         din_e;      // Effective write data
   logic [10:0]        addr_e;     // Effective address
   logic [10:0]        rda_e;      // Effective second address
   logic               we_e;       // Effective write enable
   logic [10:0]        amask;      // Valid address bits
   logic [3:0]         dbits;      // Address bit count
   logic [11:0]        depth;      // Words in current shape
   logic               wsel;       // Write address hits block
   logic               rsel;       // Read address hits block
   logic               is_fifo;    // FIFO mode
   logic               is_dp;      // Dual-port mode
   logic               full;       // FIFO full
   logic               empty;      // FIFO empty
   logic               push;       // FIFO write this cycle
   logic               pop;        // FIFO read this cycle
   logic               ram_wr;     // RAM write strobe
   logic               load_wr;    // Preload write strobe
   emb_pkg::emb_wr_s   wr;         // Array write port
   logic [10:0]        rd_loc;     // Array read address
   logic [7:0]         rd_raw;     // Array read data
   logic [7:0]         rd_gated;   // Read data, zero if unselected

   ////////////////////////////////////////////////////////////////
   // Block select
   ////////////////////////////////////////////////////////////////

   // True when cascade is off or the bits above the depth match this block's id
   function automatic logic hit
   (
      input logic [10:0] a,
      input logic [3:0]  dq,
      input logic [3:0]  cs
   );
      logic [10:0] upper;
      upper = a >> dq;
      hit = !cs[emb_pkg::EMB_CASC_EN] || (upper == {8'h00, cs[2:0]});
   endfunction

   ////////////////////////////////////////////////////////////////
   // Storage
   ////////////////////////////////////////////////////////////////

   // Single array shared by every mode
   emb_mem_core u_core
   (
      .sys_clk (sys_clk),
      .shape   (st_r.cfg.shape),
      .wr      (wr),
      .rd_addr (rd_loc),
      .rd_data (rd_raw)
   );

   ////////////////////////////////////////////////////////////////
   // Input side
   ////////////////////////////////////////////////////////////////

   // Shape decode and optional input registers
   always_comb
   begin
      amask = emb_pkg::emb_amask(st_r.cfg.shape);
      dbits = emb_pkg::emb_dbits(st_r.cfg.shape);
      depth = {1'b0, amask} + 12'h001;
      // Unregistered paths pass straight through
      din_e  = st_r.cfg.reg_din  ? st_r.din_q  : usr_i.din;
      addr_e = st_r.cfg.reg_addr ? st_r.addr_q : usr_i.addr;
      rda_e  = st_r.cfg.reg_addr ? st_r.rda_q  : usr_i.rd_addr;
      we_e   = st_r.cfg.reg_addr ? st_r.we_q   : usr_i.we;
   end

   // Mode decode and strobes
   always_comb
   begin
      is_fifo = (st_r.cfg.mode == emb_pkg::EMB_MODE_FIFO);
      is_dp   = (st_r.cfg.mode == emb_pkg::EMB_MODE_DPRAM);
      full    = (st_r.count == depth);
      empty   = (st_r.count == 12'h000);
      // Write side selects on its own address; a FIFO never cascades
      wsel = is_fifo || hit(addr_e, dbits, st_r.casc);
      rsel = is_fifo || hit(is_dp ? rda_e : addr_e, dbits, st_r.casc);
      // Strobe fires on the input-side enable, source of we is free
      ram_wr = st_r.cfg.done && in_ram_mode(st_r.cfg.mode)
               && usr_i.in_ce && we_e && wsel;
      // Push is refused when full, pop refused when empty
      push = st_r.cfg.done && is_fifo && usr_i.in_ce && we_e && !full;
      pop  = st_r.cfg.done && is_fifo && usr_i.out_ce && usr_i.pop && !empty;
      // Preload only while configuration is open
      load_wr = !st_r.cfg.done && bus_wr && (bus_addr == emb_pkg::EMB_OFS_LDDT);
   end

   // RAM write allowed in single and dual-port modes; ROM never
   function automatic logic in_ram_mode(input emb_pkg::emb_mode_e m);
      in_ram_mode = (m == emb_pkg::EMB_MODE_RAM) || (m == emb_pkg::EMB_MODE_DPRAM);
   endfunction

   ////////////////////////////////////////////////////////////////
   // Array port muxing
   ////////////////////////////////////////////////////////////////

   // One write port: preload, FIFO push, or RAM write
   always_comb
   begin
      wr.en   = 1'b0;
      wr.addr = 11'h000;
      wr.data = 8'h00;
      if (load_wr)
      begin
         // Preload pattern at the load pointer
         wr.en   = 1'b1;
         wr.addr = st_r.load_addr & amask;
         wr.data = bus_wdata[7:0];
      end
      else if (push)
      begin
         // FIFO tail
         wr.en   = 1'b1;
         wr.addr = st_r.wptr;
         wr.data = din_e;
      end
      else if (ram_wr)
      begin
         // Low address bits only; upper bits chose the block
         wr.en   = 1'b1;
         wr.addr = addr_e & amask;
         wr.data = din_e;
      end
   end

   // Read address per mode
   always_comb
   begin
      if (is_fifo)
      begin
         // Head of FIFO, first word falls through
         rd_loc = st_r.rptr;
      end
      else if (is_dp)
      begin
         // Dual port reads on its own address
         rd_loc = rda_e & amask;
      end
      else
      begin
         // RAM and ROM read where they address
         rd_loc = addr_e & amask;
      end
      // Unselected blocks drive zero so outputs can be ORed
      rd_gated = rsel ? rd_raw : 8'h00;
   end

   ////////////////////////////////////////////////////////////////
   // Next state
   ////////////////////////////////////////////////////////////////

   // All register updates
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0000_0000;
      // Input registers load on the input-side enable
      if (usr_i.in_ce)
      begin
         st_nxt.din_q  = usr_i.din;
         st_nxt.addr_q = usr_i.addr;
         st_nxt.rda_q  = usr_i.rd_addr;
         st_nxt.we_q   = usr_i.we;
      end
      // Output register loads on the output-side enable
      if (usr_i.out_ce)
      begin
         st_nxt.dout_q = rd_gated;
      end
      // FIFO pointers wrap at the shape depth
      if (push)
      begin
         st_nxt.wptr = (st_r.wptr + 11'h001) & amask;
      end
      if (pop)
      begin
         st_nxt.rptr = (st_r.rptr + 11'h001) & amask;
      end
      if (push && !pop)
      begin
         st_nxt.count = st_r.count + 12'h001;
      end
      else if (pop && !push)
      begin
         st_nxt.count = st_r.count - 12'h001;
      end
      // Preload walks forward one word per write
      if (load_wr)
      begin
         st_nxt.load_addr = (st_r.load_addr + 11'h001) & amask;
      end
      // Register writes
      if (bus_wr)
      begin
         case (bus_addr)
            emb_pkg::EMB_OFS_CTRL:
            begin
               // New shape or mode empties the FIFO
               st_nxt.cfg   = emb_pkg::emb_cfg_s'(bus_wdata[7:0]);
               st_nxt.wptr  = 11'h000;
               st_nxt.rptr  = 11'h000;
               st_nxt.count = 12'h000;
            end
            emb_pkg::EMB_OFS_LDAD:
            begin
               // Set preload start
               st_nxt.load_addr = bus_wdata[10:0];
            end
            emb_pkg::EMB_OFS_CASC:
            begin
               // Cascade id and enable
               st_nxt.casc = bus_wdata[3:0];
            end
            default:
            begin
               // Data and status need no storage here
            end
         endcase
      end
      // Register reads, answer stands for one cycle
      if (bus_rd)
      begin
         case (bus_addr)
            emb_pkg::EMB_OFS_CTRL: st_nxt.rdata = {24'h000000, st_r.cfg};
            emb_pkg::EMB_OFS_LDAD: st_nxt.rdata = {21'h000000, st_r.load_addr};
            emb_pkg::EMB_OFS_CASC: st_nxt.rdata = {28'h0000000, st_r.casc};
            emb_pkg::EMB_OFS_STAT:
            begin
               // Live FIFO level and flags
               st_nxt.rdata[11:0] = st_r.count;
               st_nxt.rdata[emb_pkg::EMB_STAT_EMPTY] = empty;
               st_nxt.rdata[emb_pkg::EMB_STAT_FULL]  = full;
               st_nxt.rdata[emb_pkg::EMB_STAT_DONE]  = st_r.cfg.done;
            end
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Registers
   ////////////////////////////////////////////////////////////////

   // Synchronous reset to RAM, 256x8, unregistered, unlocked
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_r      <= '0;
         st_r.cfg  <= emb_pkg::emb_cfg_s'(emb_pkg::EMB_CTRL_RST);
         st_r.casc <= emb_pkg::EMB_CASC_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////

   // Output register optional; bypass is combinational by design
   always_comb
   begin
      usr_o.dout  = st_r.cfg.reg_dout ? st_r.dout_q : rd_gated;
      usr_o.sel   = rsel;
      usr_o.full  = full;
      usr_o.empty = empty;
      bus_rdata   = st_r.rdata;
   end

endmodule

// ### verification/emb_memory_block_properties.sv
`timescale 1ns/1ps

// Watches the block's pins only; mode is tracked from bus writes
module emb_memory_block_properties
(
   input wire logic                  sys_clk,
   input wire logic                  rst_n,
   input wire logic [7:0]            bus_addr,
   input wire logic [31:0]           bus_wdata,
   input wire logic                  bus_wr,
   input wire logic                  bus_rd,
   input wire logic [31:0]           bus_rdata,
   input wire emb_pkg::emb_usr_in_s  usr_i,
   input wire emb_pkg::emb_usr_out_s usr_o
);
   ////////////////////////////////////////////////////////////////
   logic [7:0] cfg_r;   // Shadow of control word
   logic [3:0] casc_r;  // Shadow of cascade word
   logic [7:0] lane_m;  // Lanes valid in this shape
   logic       plain;   // Open RAM, all paths direct

   // Shadows, so each check knows the configured mode
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cfg_r  <= 8'h00;
         casc_r <= 4'h0;
      end
      else if (bus_wr && bus_addr == 8'h00)
         cfg_r <= bus_wdata[7:0];
      else if (bus_wr && bus_addr == 8'h10)
         casc_r <= bus_wdata[3:0];
   end

   // Width 8 >> shape gives the lane count
   assign lane_m = 8'hff >> (4'h8 - (4'h8 >> cfg_r[3:2]));
   assign plain  = cfg_r[7] && (cfg_r[6:0] ==? 7'b000??00);

   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_RD_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
      else $error("read data outside its slot");
   AST_CAP: assert property ($past(bus_rd) && $past(bus_addr) == 8'h0c |-> bus_rdata[11:0] <= 12'h800)
      else $error("level above capacity");
   AST_DONE: assert property ($past(bus_rd) && $past(bus_addr) == 8'h0c |-> bus_rdata[14] == $past(cfg_r[7]))
      else $error("lock flag wrong");
   AST_LANES: assert property (cfg_r[7] && !cfg_r[6] && cfg_r[1:0] != 2'h3 |-> (usr_o.dout & ~lane_m) == 8'h0)
      else $error("lane above word width");
   AST_WRITE: assert property (plain && usr_i.in_ce && usr_i.we && usr_o.sel ##1 $stable(usr_i.addr) && $stable(cfg_r)
      && $stable(casc_r) |-> usr_o.dout == ($past(usr_i.din) & lane_m))
      else $error("written word not read back");
   AST_OLD: assert property (plain && usr_i.in_ce && usr_i.we && usr_o.sel && $stable(usr_i.addr) && $stable(cfg_r)
      && $stable(casc_r) && !$past(usr_i.we) |-> usr_o.dout == $past(usr_o.dout))
      else $error("new word seen during write");
   AST_HOLD: assert property (cfg_r[6] && $stable(cfg_r) && !$past(usr_i.out_ce) && $stable(usr_o.sel)
      |-> $stable(usr_o.dout))
      else $error("output register moved without enable");
   AST_CASC: assert property (cfg_r[7] && !cfg_r[5] && !cfg_r[1] && casc_r[3]
      |-> usr_o.sel == ((usr_i.addr >> (4'h8 + cfg_r[3:2])) == {8'h0, casc_r[2:0]}))
      else $error("cascade select wrong");

   C_FULL: cover property (usr_o.full);
   C_MISS: cover property (casc_r[3] && !usr_o.sel);
   C_REG:  cover property (cfg_r[6] && usr_i.out_ce);
endmodule

bind emb_memory_block emb_memory_block_properties u_props
(
   .sys_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .usr_i, .usr_o
);

// ### verification/emb_user_logic.sv
`timescale 1ns/1ps

// Stand-in for the array logic feeding the block's user side
module emb_user_logic
(
   input  wire logic                 glob_we,
   input  wire logic                 use_glob,
   input  wire emb_pkg::emb_usr_in_s cmd,
   output emb_pkg::emb_usr_in_s      usr_i
);
   ////////////////////////////////////////////////////////////////
   // Source select; no extra stage, so the bench timing stays exact
   always_comb
   begin
      usr_i       = cmd;
      usr_i.we    = use_glob ? glob_we : cmd.we;
      usr_i.in_ce = use_glob ? 1'b1 : cmd.in_ce;
   end
endmodule

// ### verification/emb_memory_block_tb.sv
`timescale 1ns/1ps

module emb_memory_block_tb;
   ////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [1:0]  shp;
      logic [10:0] a;
      logic [7:0]  d;
      logic [7:0]  q;
   } emb_row_s;

   logic                  sys_clk;
   logic                  rst_n;
   logic [7:0]            bus_addr;
   logic [31:0]           bus_wdata;
   logic                  bus_wr;
   logic                  bus_rd;
   logic [31:0]           bus_rdata;
   logic                  glob_we;
   logic                  use_glob;
   emb_pkg::emb_usr_in_s  cmd;
   emb_pkg::emb_usr_in_s  usr_i;
   emb_pkg::emb_usr_out_s usr_o;
   int                    err_total;
   int                    comparisons;
   // Top word of each shape, plus masked lanes
   emb_row_s              rows [5] = '{'{2'h0, 11'h0ff, 8'ha5, 8'ha5}, '{2'h1, 11'h1ff, 8'h3c, 8'h0c},
                                       '{2'h2, 11'h3ff, 8'h0e, 8'h02}, '{2'h3, 11'h7ff, 8'h01, 8'h01},
                                       '{2'h3, 11'h000, 8'hfe, 8'h00}};
   logic [31:0]           regs [2] = '{32'hc0, 32'ha0};

   emb_user_logic u_usr (.glob_we(glob_we), .use_glob(use_glob), .cmd(cmd), .usr_i(usr_i));
   emb_memory_block u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .usr_i(usr_i), .usr_o(usr_o));

   // 100 ns period
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic cd(input logic [7:0] e);
      #1 chk({24'h0, usr_o.dout}, {24'h0, e});
   endtask

   // Bus cycles leave one idle edge between strobes
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge sys_clk);
      bus_wr    <= 1'b0;
   endtask

   task automatic br(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge sys_clk);
      bus_rd   <= 1'b0;
      #1 chk(bus_rdata, e);
   endtask

   // User side; a write lands at the following edge
   task automatic uw(input logic [10:0] a, input logic [7:0] d, input logic we);
      @(posedge sys_clk);
      cmd.addr <= a;
      cmd.din  <= d;
      cmd.we   <= we;
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog, far beyond the roughly 360 cycles needed
   initial
   begin
      #300000;
      err_total++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////
   initial
   begin
      err_total = 0;
      comparisons = 0;
      rst_n = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 32'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      glob_we = 1'b0;
      use_glob = 1'b0;
      cmd = '0;
      cmd.in_ce = 1'b1;
      cmd.out_ce = 1'b1;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      br(8'h00, 32'h0);
      br(8'h0c, 32'h1000);
      br(8'h10, 32'h0);
      br(8'h14, 32'h0);
      // Every shape, at its top word
      foreach (rows[i])
      begin
         bw(8'h00, {24'h0, 4'h8, rows[i].shp, 2'h0});
         uw(rows[i].a, rows[i].d, 1'b1);
         uw(rows[i].a, 8'h00, 1'b0);
         cd(rows[i].q);
      end
      // Same-cycle read sees the old word
      bw(8'h00, 32'h80);
      uw(11'h005, 8'h11, 1'b1);
      uw(11'h005, 8'h22, 1'b1);
      cd(8'h11);
      uw(11'h006, 8'h66, 1'b1);
      uw(11'h005, 8'h00, 1'b0);
      cd(8'h22);
      // Output register, then address register: one cycle lag
      foreach (regs[i])
      begin
         // Each pass starts on the old word at 5
         uw(11'h005, 8'h00, 1'b0);
         bw(8'h00, regs[i]);
         uw(11'h006, 8'h00, 1'b0);
         cd(8'h22);
         @(posedge sys_clk);
         cd(8'h66);
      end
      bw(8'h00, 32'hc0);
      @(posedge sys_clk);
      cmd.out_ce <= 1'b0;
      cmd.addr <= 11'h005;
      repeat (2) @(posedge sys_clk);
      cd(8'h66);
      @(posedge sys_clk);
      cmd.out_ce <= 1'b1;
      // Second read port
      bw(8'h00, 32'h82);
      uw(11'h007, 8'h7e, 1'b1);
      cmd.rd_addr <= 11'h007;
      uw(11'h003, 8'h00, 1'b0);
      cd(8'h7e);
      // Preload, lock, then user write must not stick
      bw(8'h00, 32'h01);
      bw(8'h04, 32'h10);
      bw(8'h08, 32'h77);
      bw(8'h08, 32'h88);
      bw(8'h00, 32'h81);
      br(8'h08, 32'h0);
      uw(11'h011, 8'h00, 1'b1);
      uw(11'h011, 8'h00, 1'b0);
      cd(8'h88);
      uw(11'h010, 8'h00, 1'b0);
      cd(8'h77);
      // Write enable from the global line
      bw(8'h00, 32'h80);
      uw(11'h020, 8'h5a, 1'b0);
      use_glob <= 1'b1;
      glob_we <= 1'b1;
      @(posedge sys_clk);
      glob_we <= 1'b0;
      use_glob <= 1'b0;
      cd(8'h5a);
      // Input side idle: a write without its enable is dropped
      uw(11'h020, 8'h99, 1'b1);
      cmd.in_ce <= 1'b0;
      uw(11'h020, 8'h00, 1'b0);
      cmd.in_ce <= 1'b1;
      cd(8'h5a);
      // Depth cascade, block id 1
      bw(8'h10, 32'h9);
      uw(11'h105, 8'h55, 1'b1);
      uw(11'h105, 8'h00, 1'b0);
      #1 chk({23'h0, usr_o.sel, usr_o.dout}, 32'h155);
      // Overwrite on a held address; old word must stand for that cycle
      uw(11'h105, 8'haa, 1'b1);
      #1 chk({23'h0, usr_o.sel, usr_o.dout}, 32'h155);
      uw(11'h005, 8'h00, 1'b0);
      #1 chk({23'h0, usr_o.sel, usr_o.dout}, 32'h0);
      bw(8'h10, 32'h0);
      // FIFO: fill past full, one pop, then clear by control write
      bw(8'h00, 32'h83);
      uw(11'h000, 8'h31, 1'b1);
      uw(11'h000, 8'h32, 1'b1);
      repeat (256) @(posedge sys_clk);
      cmd.we <= 1'b0;
      #1 chk({22'h0, usr_o.full, usr_o.empty, usr_o.dout}, 32'h231);
      br(8'h0c, 32'h6100);
      @(posedge sys_clk);
      cmd.pop <= 1'b1;
      @(posedge sys_clk);
      cmd.pop <= 1'b0;
      cd(8'h32);
      bw(8'h00, 32'h83);
      br(8'h0c, 32'h5000);
      end_sim();
   end
endmodule
